// File: src/quad_io_read_wrap_logic.v
// Quad I/O read sequencer with continuous read mode and burst wrap
`timescale 1ns/1ps
`include "quad_read_defs.vh"

// Function
// - Quad read: quad address, four dummy clocks
// - Quad read commands need quad enable set; continuous reads skip the check
// - Mode byte follows address; low nibble ignored
// - Select 10 skips next command byte
// - Other select needs full command next
// - Quad instruction dummy 2/4/6/8, default two
// - Quad instruction mode keeps continuous and wrap
// - Word read: even address, two dummies
// - Word read honours continuous read select
// - Aligned read: 16-byte address, no dummies
// - Aligned read honours continuous read select
// - Wrap command: code, 24 ignored, 8 bits
// - Wrap length field picks 8..64 bytes
// - Wrap inside section until chip select rises
// - Wrap setting persists for later reads
// - Power-on wrap disabled
// - Read parameter bits select quad dummy count
// - Sample on rise, shift out on fall
// - Address increments after each byte
module quad_io_read_wrap_logic (
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire        cs_n_pin,
   input  wire        sclk_pin,
   input  wire [3:0]  io_in,
   output reg  [3:0]  io_out,
   output reg  [3:0]  io_oe,
   input  wire        quad_enable_bit,
   input  wire        quad_instruction_mode,
   input  wire [1:0]  read_param_dummy,
   output reg  [23:0] mem_addr,
   output reg         mem_rd,
   input  wire [7:0]  mem_data,
   output wire        wrap_disable_bit,
   output wire [1:0]  wrap_length_field,
   output reg         continuous_read_active,
   output wire        read_busy
);

   localparam S_IDLE  = 3'd0;
   localparam S_CMD   = 3'd1;
   localparam S_ADDR  = 3'd2;
   localparam S_MODE  = 3'd3;
   localparam S_DUMMY = 3'd4;
   localparam S_DATA  = 3'd5;
   localparam S_WRAP  = 3'd6;
   localparam S_SKIP  = 3'd7;

   wire        cs_n_s;
   wire        cs_sel_s;
   wire        sclk_s;
   wire [3:0]  io_s;
   reg         sclk_d_r;
   wire        sclk_rise;
   wire        sclk_fall;

   reg  [2:0]  state_r;
   reg  [4:0]  cnt_r;
   reg  [31:0] sh_r;
   reg  [7:0]  cmd_r;
   reg  [3:0]  lo_r;
   reg         hi_r;
   reg  [2:0]  wrap_r;
   reg  [3:0]  dummy_need;
   reg         cmd_known;
   wire [31:0] sh_quad;
   wire [31:0] sh_one;
   wire [7:0]  cmd_in;
   wire [4:0]  cmd_clks;
   wire [23:0] addr_in;
   wire [23:0] addr_next;
   wire        wrap_on;

   // Pin inputs through two flops each; select inverted so reset reads idle
   sync_two_stage #(.WIDTH(6)) u_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .din     ({~cs_n_pin, sclk_pin, io_in}),
      .dout    ({cs_sel_s, sclk_s, io_s})
   );

   // Deselected while the synchroniser is in reset, no false frame start
   assign cs_n_s = ~cs_sel_s;

   // Delayed serial clock for edge finding
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
      end
   end

   // Edges only count while selected
   assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

   // Shift in one line or four, MSB first
   assign sh_quad  = {sh_r[27:0], io_s};
   assign sh_one   = {sh_r[30:0], io_s[0]};
   assign cmd_in   = quad_instruction_mode ? sh_quad[7:0] : sh_one[7:0];
   assign cmd_clks = quad_instruction_mode ? `QPI_CMD_CLKS : `SPI_CMD_CLKS;
   assign addr_in  = sh_quad[23:0];

   // Wrap state seen by software and the address stepper
   assign wrap_disable_bit  = wrap_r[`WRAP_DIS_POS];
   assign wrap_length_field = wrap_r[`WRAP_LEN_LSB+1:`WRAP_LEN_LSB];
   assign read_busy         = (state_r != S_IDLE);

   // Wrap applies to quad read and word read only
   assign wrap_on = ~wrap_r[`WRAP_DIS_POS] &
                    ((cmd_r == `CMD_QUAD_READ) || (cmd_r == `CMD_WORD_QUAD_READ));

   wrap_addr_step u_step (
      .addr              (mem_addr),
      .wrap_on           (wrap_on),
      .wrap_length_field (wrap_length_field),
      .addr_next         (addr_next)
   );

   // Dummy clocks for the current read command
   always @* begin
      dummy_need = `DUMMY_QUAD_SPI;
      case (cmd_r)
         `CMD_QUAD_READ: begin
            if (quad_instruction_mode) begin
               dummy_need = {read_param_dummy, 1'b0} + 4'h2;
            end else begin
               dummy_need = `DUMMY_QUAD_SPI;
            end
         end
         `CMD_WORD_QUAD_READ: begin
            dummy_need = `DUMMY_WORD;
         end
         `CMD_ALIGN_QUAD_READ: begin
            dummy_need = `DUMMY_ALIGN;
         end
         default: begin
            dummy_need = `DUMMY_QUAD_SPI;
         end
      endcase
   end

   // Which decoded commands this block serves
   always @* begin
      cmd_known = 1'b0;
      case (cmd_in)
         `CMD_QUAD_READ: begin
            cmd_known = quad_enable_bit;
         end
         `CMD_WORD_QUAD_READ, `CMD_ALIGN_QUAD_READ: begin
            cmd_known = quad_enable_bit & ~quad_instruction_mode;
         end
         `CMD_SET_WRAP: begin
            cmd_known = 1'b1;
         end
         default: begin
            cmd_known = 1'b0;
         end
      endcase
   end

   // Main sequencer
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r                <= S_IDLE;
         cnt_r                  <= 5'h00;
         sh_r                   <= 32'h0000_0000;
         cmd_r                  <= 8'h00;
         lo_r                   <= 4'h0;
         hi_r                   <= 1'b1;
         wrap_r                 <= `WRAP_RESET;
         continuous_read_active <= 1'b0;
         io_out                 <= 4'h0;
         io_oe                  <= 4'h0;
         mem_addr               <= 24'h00_0000;
         mem_rd                 <= 1'b0;
      end else begin
         mem_rd <= 1'b0;
         if (cs_n_s) begin
            // Chip select high ends any sequence and frees the lines
            state_r <= S_IDLE;
            io_oe   <= 4'h0;
            cnt_r   <= 5'h00;
         end else begin
            case (state_r)
               S_IDLE: begin
                  cnt_r <= 5'h00;
                  hi_r  <= 1'b1;
                  if (continuous_read_active) begin
                     state_r <= S_ADDR;
                  end else begin
                     state_r <= S_CMD;
                  end
               end
               S_CMD: begin
                  if (sclk_rise) begin
                     sh_r  <= quad_instruction_mode ? sh_quad : sh_one;
                     cnt_r <= cnt_r + 5'h01;
                     if (cnt_r == cmd_clks - 5'h01) begin
                        cnt_r <= 5'h00;
                        cmd_r <= cmd_in;
                        if (!cmd_known) begin
                           state_r <= S_SKIP;
                        end else if (cmd_in == `CMD_SET_WRAP) begin
                           state_r <= S_WRAP;
                        end else begin
                           state_r <= S_ADDR;
                        end
                     end
                  end
               end
               S_ADDR: begin
                  if (sclk_rise) begin
                     sh_r  <= sh_quad;
                     cnt_r <= cnt_r + 5'h01;
                     if (cnt_r == `ADDR_CLKS - 5'h01) begin
                        cnt_r   <= 5'h00;
                        state_r <= S_MODE;
                        if (cmd_r == `CMD_WORD_QUAD_READ) begin
                           mem_addr <= addr_in & `WORD_ADDR_MASK;
                        end else if (cmd_r == `CMD_ALIGN_QUAD_READ) begin
                           mem_addr <= addr_in & `ALIGN_ADDR_MASK;
                        end else begin
                           mem_addr <= addr_in;
                        end
                     end
                  end
               end
               S_MODE: begin
                  if (sclk_rise) begin
                     cnt_r <= cnt_r + 5'h01;
                     if (cnt_r == 5'h00) begin
                        // Upper nibble holds the select; io1/io0 are bits 5/4
                        continuous_read_active <=
                           (io_s[1:0] == `CONT_SELECT_KEEP);
                     end
                     if (cnt_r == `MODE_CLKS - 5'h01) begin
                        // Lower nibble is ignored
                        cnt_r <= 5'h00;
                        if (dummy_need == 4'h0) begin
                           state_r <= S_DATA;
                        end else begin
                           state_r <= S_DUMMY;
                        end
                     end
                  end
               end
               S_DUMMY: begin
                  if (sclk_rise) begin
                     cnt_r <= cnt_r + 5'h01;
                     if (cnt_r == {1'b0, dummy_need} - 5'h01) begin
                        cnt_r   <= 5'h00;
                        state_r <= S_DATA;
                     end
                  end
               end
               S_DATA: begin
                  // Host has released the lines before this fall
                  if (sclk_fall) begin
                     io_oe <= 4'hF;
                     hi_r  <= ~hi_r;
                     if (hi_r) begin
                        io_out <= mem_data[7:4];
                        lo_r   <= mem_data[3:0];
                        mem_rd <= 1'b1;
                     end else begin
                        io_out   <= lo_r;
                        mem_addr <= addr_next;
                     end
                  end
               end
               S_WRAP: begin
                  if (sclk_rise) begin
                     sh_r  <= sh_quad;
                     cnt_r <= cnt_r + 5'h01;
                     if (cnt_r == `WRAP_CLKS - 5'h01) begin
                        // Top nibble is now in sh_r[3:0]; W7 and W3-0 dropped
                        wrap_r  <= sh_r[2:0];
                        cnt_r   <= 5'h00;
                        state_r <= S_SKIP;
                     end
                  end
               end
               S_SKIP: begin
                  state_r <= S_SKIP;
               end
               default: begin
                  state_r <= S_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// File: src/quad_read_defs.vh
// Constants for the quad read and burst-wrap command sequencer
`ifndef QUAD_READ_DEFS_VH
`define QUAD_READ_DEFS_VH

// Command codes
`define CMD_QUAD_READ       8'hEB
`define CMD_WORD_QUAD_READ  8'hE7
`define CMD_ALIGN_QUAD_READ 8'hE3
`define CMD_SET_WRAP        8'h77

// Phase lengths in serial clocks
`define SPI_CMD_CLKS        5'h08
`define QPI_CMD_CLKS        5'h02
`define ADDR_CLKS           5'h06
`define MODE_CLKS           5'h02
`define WRAP_CLKS           5'h08

// Dummy clocks per command
`define DUMMY_QUAD_SPI      4'h4
`define DUMMY_WORD          4'h2
`define DUMMY_ALIGN         4'h0

// Continuous read select value that skips the command byte
`define CONT_SELECT_KEEP    2'b10

// Wrap setting: wrap_disable_bit at bit 0, length field at bits 2:1
`define WRAP_RESET          3'h1
`define WRAP_DIS_POS        0
`define WRAP_LEN_LSB        1

// Address masks for word and aligned reads
`define WORD_ADDR_MASK      24'hFF_FFFE
`define ALIGN_ADDR_MASK     24'hFF_FFF0

`endif

// File: src/sync_two_stage.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_two_stage #(
   parameter WIDTH = 1
) (
   input  wire             mclk,
   input  wire             sys_rst,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] meta_r;

   // First stage feeds only the second
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= {WIDTH{1'b0}};
         dout   <= {WIDTH{1'b0}};
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule

// File: src/wrap_addr_step.v
// Next read address with optional wrap inside an aligned section
`timescale 1ns/1ps
module wrap_addr_step (
   input  wire [23:0] addr,
   input  wire        wrap_on,
   input  wire [1:0]  wrap_length_field,
   output wire [23:0] addr_next
);

   wire [7:0] sect_mask;
   wire [7:0] low_inc;

   // Section of 8, 16, 32 or 64 bytes
   assign sect_mask = (8'h08 << wrap_length_field) - 8'h01;
   assign low_inc   = addr[7:0] + 8'h01;

   // Wrap keeps upper bits, plain mode counts through
   assign addr_next = wrap_on ?
      {addr[23:8], (addr[7:0] & ~sect_mask) | (low_inc & sect_mask)} :
      addr + 24'h00_0001;

endmodule

// File: testbench/quad_read_chk.sv
// Port assertions for the quad read sequencer
`timescale 1ns/1ps
module quad_read_chk (
   input wire        mclk,
   input wire        sys_rst,
   input wire        cs_n_pin,
   input wire [3:0]  io_oe,
   input wire        quad_enable_bit,
   input wire [23:0] mem_addr,
   input wire        mem_rd,
   input wire        wrap_disable_bit,
   input wire [1:0]  wrap_length_field,
   input wire        continuous_read_active,
   input wire        read_busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Reset state, drive rules and address stepping
   chk_wrap_off_init: assert property ($fell(sys_rst) |-> wrap_disable_bit)
      else $error("wrap on after reset");
   chk_quad_gate: assert property ($rose(io_oe[0]) |-> quad_enable_bit)
      else $error("drive with quad enable low");
   chk_lines_same: assert property (io_oe == 4'h0 || io_oe == 4'hF)
      else $error("partial output enable");
   chk_idle_quiet: assert property (cs_n_pin [*8] |-> io_oe == 4'h0)
      else $error("drive with chip select high");
   chk_fetch_pulse: assert property (mem_rd |=> !mem_rd)
      else $error("fetch strobe too long");
   chk_addr_plus_one: assert property (
      io_oe[0] && $past(io_oe[0]) && $changed(mem_addr) && wrap_disable_bit
      |-> mem_addr == $past(mem_addr) + 24'h1) else $error("address step");
   chk_wrap_section: assert property (
      io_oe[0] && $past(io_oe[0]) && $changed(mem_addr) && !wrap_disable_bit
      |-> ((mem_addr ^ $past(mem_addr)) >> (wrap_length_field + 3)) == 24'h0)
      else $error("left wrap section");
   chk_cont_in_frame: assert property ($rose(continuous_read_active) |-> read_busy)
      else $error("continuous set outside frame");
   chk_wrap_by_cmd: assert property (
      $changed(wrap_length_field) || $changed(wrap_disable_bit) |-> $past(read_busy))
      else $error("wrap setting changed idle");
endmodule

bind quad_io_read_wrap_logic quad_read_chk chk_i (
   .mclk(mclk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .io_oe(io_oe),
   .quad_enable_bit(quad_enable_bit), .mem_addr(mem_addr), .mem_rd(mem_rd),
   .wrap_disable_bit(wrap_disable_bit), .wrap_length_field(wrap_length_field),
   .continuous_read_active(continuous_read_active), .read_busy(read_busy));

// File: testbench/host_link_model.sv
// Host controller model driving the quad serial link
`timescale 1ns/1ps
module host_link_model (
   output reg        cs_n,
   output reg        sclk,
   output reg  [3:0] drv,
   output reg        drv_en,
   input  wire [3:0] io
);
   // Idle link: clock low, lines released
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      drv = 4'h0;
      drv_en = 1'b0;
   end
   // One nibble in, taken by the device on the rise
   task put(input [3:0] v, input rel);
      begin
         drv = v;
         drv_en = 1'b1;
         #160 sclk = 1'b1;
         #80 drv_en = !rel;
         #80 sclk = 1'b0;
      end
   endtask
   // Dummy clock with lines released
   task idle_clk;
      begin
         drv_en = 1'b0;
         #160 sclk = 1'b1;
         #160 sclk = 1'b0;
      end
   endtask
   // Nibble out, sampled late while it still stands
   task get(output [3:0] v);
      begin
         #160 sclk = 1'b1;
         #150 v = io;
         #10 sclk = 1'b0;
      end
   endtask
   // Open a frame
   task begin_frame;
      begin
         cs_n = 1'b0;
      end
   endtask
   // Close frame and keep chip select high two periods
   task end_frame;
      begin
         #160 cs_n = 1'b1;
         drv_en = 1'b0;
         #640;
      end
   endtask
   // Ones on line zero for eight clocks leave continuous mode
   task leave_cont;
      integer i;
      begin
         cs_n = 1'b0;
         for (i = 0; i < 8; i = i + 1)
            put(4'h1, i == 7);
         end_frame;
      end
   endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the quad read sequencer
`timescale 1ns/1ps
`include "quad_read_defs.vh"
module tb_top;
   reg         mclk, sys_rst, quad_enable_bit, quad_instruction_mode, won;
   reg  [1:0]  read_param_dummy, wl;
   wire        cs_n_pin, sclk_pin, drv_en, mem_rd, wrap_disable_bit;
   wire        continuous_read_active, read_busy;
   wire [3:0]  drv, io_out, io_oe, io_in;
   wire [1:0]  wrap_length_field;
   wire [23:0] mem_addr;
   wire [7:0]  mem_data;
   integer     err_count, n_checks, k;
   // Lines pulled high when nobody drives; array stand-in
   assign io_in = drv_en ? drv : (io_oe & io_out) | ~io_oe;
   assign mem_data = mem_addr[7:0] ^ 8'h3C;
   quad_io_read_wrap_logic uut (.mclk(mclk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin),
      .sclk_pin(sclk_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
      .quad_enable_bit(quad_enable_bit), .quad_instruction_mode(quad_instruction_mode),
      .read_param_dummy(read_param_dummy), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_data(mem_data), .wrap_disable_bit(wrap_disable_bit),
      .wrap_length_field(wrap_length_field),
      .continuous_read_active(continuous_read_active), .read_busy(read_busy));
   host_link_model hst (.cs_n(cs_n_pin), .sclk(sclk_pin), .drv(drv), .drv_en(drv_en),
      .io(io_in));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Next expected byte address, wrapping inside the section when enabled
   function [23:0] step(input [23:0] a);
      reg [23:0] m;
      begin
         m = won ? (24'h00_0008 << wl) - 24'h00_0001 : 24'hFF_FFFF;
         step = (a & ~m) | ((a + 24'h00_0001) & m);
      end
   endfunction
   // One frame; n bytes expected from e, or none driven when n is zero
   task rd(input [7:0] c, input sk, input [23:0] a, input [7:0] m, input [3:0] nd,
           input integer n, input [23:0] e);
      integer i;
      reg [3:0] hi, lo;
      begin
         hst.begin_frame;
         if (!sk && quad_instruction_mode) begin
            hst.put(c[7:4], 1'b0);
            hst.put(c[3:0], 1'b0);
         end else if (!sk)
            for (i = 7; i >= 0; i = i - 1) hst.put({3'b000, c[i]}, 1'b0);
         for (i = 5; i >= 0; i = i - 1) hst.put(a[4*i +: 4], 1'b0);
         hst.put(m[7:4], 1'b0);
         hst.put(m[3:0], 1'b1);
         repeat (nd) hst.idle_clk;
         for (i = 0; i < n; i = i + 1) begin
            hst.get(hi);
            hst.get(lo);
            chk({hi, lo}, e[7:0] ^ 8'h3C);
            e = step(e);
         end
         #100;
         if (n == 0) chk(io_oe, 4'h0);
         hst.end_frame;
         chk(read_busy, 1'b0);
      end
   endtask
   task t_quad;
      begin
         rd(`CMD_QUAD_READ, 0, 24'h00_12FE, 8'h2F, `DUMMY_QUAD_SPI, 3, 24'h00_12FE);
         chk(continuous_read_active, 1'b1);
         rd(8'h00, 1, 24'h00_0400, 8'hF5, 4, 2, 24'h00_0400);
         chk(continuous_read_active, 1'b0);
         rd(`CMD_QUAD_READ, 0, 24'h00_0555, 8'h00, 4, 1, 24'h00_0555);
      end
   endtask
   task t_word;
      begin
         rd(`CMD_WORD_QUAD_READ, 0, 24'h00_0101, 8'h25, `DUMMY_WORD, 2, 24'h00_0100);
         chk(continuous_read_active, 1'b1);
         rd(8'h00, 1, 24'h00_0203, 8'h2A, 2, 1, 24'h00_0202);
         hst.leave_cont;
         chk(continuous_read_active, 1'b0);
      end
   endtask
   task t_align;
      begin
         rd(`CMD_ALIGN_QUAD_READ, 0, 24'h00_0137, 8'h20, `DUMMY_ALIGN, 2, 24'h00_0130);
         chk(continuous_read_active, 1'b1);
         rd(8'h00, 1, 24'h00_0248, 8'hFF, 0, 1, 24'h00_0240);
      end
   endtask
   task t_qe;
      begin
         @(posedge mclk) #1 quad_enable_bit = 1'b0;
         rd(`CMD_QUAD_READ, 0, 24'h00_0010, 8'h20, 4, 0, 24'h00_0000);
         rd(`CMD_WORD_QUAD_READ, 0, 24'h00_0010, 8'h20, 2, 0, 24'h00_0000);
         rd(`CMD_ALIGN_QUAD_READ, 0, 24'h00_0010, 8'h20, 0, 0, 24'h00_0000);
         chk(continuous_read_active, 1'b0);
         @(posedge mclk) #1 quad_enable_bit = 1'b1;
      end
   endtask
   task t_wrap;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            // Top wrap bit set, wrap enabled, length from k, low nibble ignored
            rd(`CMD_SET_WRAP, 0, 24'hA5_5A5A, {1'b1, k[1:0], 1'b0, 4'hF}, 0, 0, 0);
            won = 1'b1;
            wl = k[1:0];
            chk({wrap_disable_bit, wrap_length_field}, {1'b0, k[1:0]});
            rd(`CMD_QUAD_READ, 0, 24'h00_03F5, 8'h00, 4, (8 << k) + 2, 24'h00_03F5);
            rd(`CMD_WORD_QUAD_READ, 0, 24'h00_07F3, 8'h00, 2, 10, 24'h00_07F2);
         end
         @(posedge mclk) #1 sys_rst = 1'b1;
         repeat (8) @(posedge mclk);
         #1 sys_rst = 1'b0;
         chk(wrap_disable_bit, 1'b1);
         rd(`CMD_SET_WRAP, 0, 24'h00_0000, 8'h10, 0, 0, 0);
         won = 1'b0;
         rd(`CMD_QUAD_READ, 0, 24'h00_00FE, 8'h00, 4, 3, 24'h00_00FE);
      end
   endtask
   task t_qim;
      begin
         @(posedge mclk) #1 quad_instruction_mode = 1'b1;
         for (k = 0; k < 4; k = k + 1) begin
            @(posedge mclk) #1 read_param_dummy = k[1:0];
            rd(`CMD_QUAD_READ, 0, 24'h00_0A00 + k, 8'h00, {k[2:0], 1'b0} + 4'h2, 2,
               24'h00_0A00 + k);
         end
         rd(`CMD_QUAD_READ, 0, 24'h00_0B0F, 8'h20, 8, 1, 24'h00_0B0F);
         rd(8'h00, 1, 24'h00_0C01, 8'hF0, 8, 1, 24'h00_0C01);
         @(posedge mclk) #1 quad_instruction_mode = 1'b0;
      end
   endtask
   task stop_test;
      begin
         if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      quad_enable_bit = 1'b1;
      quad_instruction_mode = 1'b0;
      read_param_dummy = 2'b00;
      won = 1'b0;
      wl = 2'b00;
      err_count = 0;
      n_checks = 0;
      repeat (8) @(posedge mclk);
      #1 sys_rst = 1'b0;
      chk({wrap_disable_bit, wrap_length_field}, 3'b100);
      t_quad;
      t_word;
      t_align;
      t_qe;
      t_wrap;
      t_qim;
      stop_test;
   end
   // Watchdog
   initial begin
      #1_500_000;
      err_count = err_count + 1;
      stop_test;
   end
endmodule
